/* core/spg_top.sv */
// Overview of operation
// - Four pattern slots, each with length, width and count; start picks one.
// - Output timing advances only on drive pulses, never on clock time.
// - Start before motion arms; output begins with the first drive pulse.
// - Generator halts itself after the configured number of pulses.
// - Stop command from register or jog pins ends the output.
// - Stop while output is high waits for the full ON width first.
// - Drive stop drops output at once and halts the generator.
// - After a drive stop nothing resumes; a new start begins afresh.
// - Period length is a 16-bit count, 2 to 65535, defaults 10/20/1000/10000.
// - ON width accepts 1 to 65534, defaults 5/10/500/5000.
// - Pulse count 1 to 65535; zero means run until stopped.
// - All pattern values are raw drive pulses with no scaling.
// - Program command latency of a few milliseconds is tolerated.
//
// Local design decisions: register access over APB and the register addresses.
`include "spg_defines.svh"
`timescale 1ns/1ns
`default_nettype none

module spg_top #(
    parameter int SLOTS = 4,
    parameter int CW = 16
) (
    // APB clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive pulse stream
    input wire logic drive_pulse,
    input wire logic drive_active,
    // Jog commands
    input wire logic jog_start_cmd,
    input wire logic [1:0] jog_slot,
    input wire logic jog_stop_cmd,
    // Position synchronous output
    output logic position_sync_out
);

    // ==========================================
    // Slot storage
    logic [CW-1:0] len_q [SLOTS];
    logic [CW-1:0] wid_q [SLOTS];
    logic [CW-1:0] cnt_q [SLOTS];
    logic [CW-1:0] act_len_q, act_wid_q, act_cnt_q;
    logic [CW-1:0] phase_q, emit_q;
    logic [1:0] slot_q;
    spg_pkg::spg_state_t state_q;
    logic out_q, drive_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;

    function automatic logic [CW-1:0] slot_rst(input spg_pkg::spg_field_t f, input int i);
        logic [CW-1:0] v;
        v = '0;
        unique case (f)
            spg_pkg::SPG_FLD_LEN: v = (i == 0) ? `SPG_LEN_RST0 : (i == 1) ? `SPG_LEN_RST1 :
                (i == 2) ? `SPG_LEN_RST2 : `SPG_LEN_RST3;
            spg_pkg::SPG_FLD_WID: v = (i == 0) ? `SPG_WID_RST0 : (i == 1) ? `SPG_WID_RST1 :
                (i == 2) ? `SPG_WID_RST2 : `SPG_WID_RST3;
            default: v = (i == 0) ? `SPG_CNT_RST0 : (i == 1) ? `SPG_CNT_RST1 :
                (i == 2) ? `SPG_CNT_RST2 : `SPG_CNT_RST3;
        endcase
        return v;
    endfunction

    function automatic logic [11:0] slot_addr(input int i, input logic [11:0] ofs);
        return 12'(`SPG_OFS_SLOT_BASE + `SPG_SLOT_STRIDE * i + ofs);
    endfunction

    // ==========================================
    // APB decode
    logic commit, wr, mapped;
    logic start_req, stop_req, drive_stop;
    logic [1:0] start_slot;

    assign commit = psel & penable & pready_q;
    assign wr = commit & pwrite;

    always_comb begin
        mapped = (paddr == `SPG_OFS_CTRL) || (paddr == `SPG_OFS_STATUS) || (paddr == `SPG_OFS_EMIT);
        for (int i = 0; i < SLOTS; i++) begin
            if (paddr == slot_addr(i, `SPG_OFS_LEN) || paddr == slot_addr(i, `SPG_OFS_WID) ||
                paddr == slot_addr(i, `SPG_OFS_CNT)) begin
                mapped = 1'b1;
            end
        end
    end

    // Commands from program register or jog pins
    always_comb begin
        start_req = jog_start_cmd;
        stop_req = jog_stop_cmd;
        start_slot = jog_slot;
        if (wr && paddr == `SPG_OFS_CTRL) begin
            start_req = jog_start_cmd | pwdata[`SPG_CTRL_START];
            stop_req = jog_stop_cmd | pwdata[`SPG_CTRL_STOP];
            if (pwdata[`SPG_CTRL_START]) begin
                start_slot = pwdata[`SPG_CTRL_SLOT_HI:`SPG_CTRL_SLOT_LO];
            end
        end
    end

    assign drive_stop = drive_q & ~drive_active;

    // One wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            pslverr_q <= psel & penable & ~pready_q & ~mapped;
            prdata_q <= 32'h0000_0000;
            if (psel && penable && !pready_q && !pwrite) begin
                if (paddr == `SPG_OFS_STATUS) begin
                    prdata_q[`SPG_STAT_STATE_HI:`SPG_STAT_STATE_LO] <= state_q;
                    prdata_q[`SPG_STAT_OUT] <= out_q;
                    prdata_q[`SPG_STAT_SLOT_HI:`SPG_STAT_SLOT_LO] <= slot_q;
                end
                if (paddr == `SPG_OFS_EMIT) begin
                    prdata_q[CW-1:0] <= emit_q;
                end
                for (int i = 0; i < SLOTS; i++) begin
                    if (paddr == slot_addr(i, `SPG_OFS_LEN)) prdata_q[CW-1:0] <= len_q[i];
                    if (paddr == slot_addr(i, `SPG_OFS_WID)) prdata_q[CW-1:0] <= wid_q[i];
                    if (paddr == slot_addr(i, `SPG_OFS_CNT)) prdata_q[CW-1:0] <= cnt_q[i];
                end
            end
        end
    end

    // ==========================================
    // Pattern slot writes, raw drive pulse units
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SLOTS; i++) begin
                len_q[i] <= slot_rst(spg_pkg::SPG_FLD_LEN, i);
                wid_q[i] <= slot_rst(spg_pkg::SPG_FLD_WID, i);
                cnt_q[i] <= slot_rst(spg_pkg::SPG_FLD_CNT, i);
            end
        end else begin
            for (int i = 0; i < SLOTS; i++) begin
                if (wr && paddr == slot_addr(i, `SPG_OFS_LEN)) len_q[i] <= pwdata[CW-1:0];
                if (wr && paddr == slot_addr(i, `SPG_OFS_WID)) wid_q[i] <= pwdata[CW-1:0];
                if (wr && paddr == slot_addr(i, `SPG_OFS_CNT)) cnt_q[i] <= pwdata[CW-1:0];
            end
        end
    end

    // ==========================================
    // Drive activity tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_q <= 1'b0;
        end else begin
            drive_q <= drive_active;
        end
    end

    // ==========================================
    // Generator
    logic [CW-1:0] phase_nx;
    logic fall_now, last_done;

    assign phase_nx = (phase_q == act_len_q - 1'b1) ? '0 : phase_q + 1'b1;
    assign fall_now = drive_pulse && phase_q != '0 && phase_q == act_wid_q;
    assign last_done = act_cnt_q != '0 && emit_q == act_cnt_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= spg_pkg::SPG_IDLE;
            out_q <= 1'b0;
            phase_q <= '0;
            emit_q <= '0;
            slot_q <= 2'h0;
            act_len_q <= CW'(`SPG_LEN_RST0);
            act_wid_q <= CW'(`SPG_WID_RST0);
            act_cnt_q <= CW'(`SPG_CNT_RST0);
        end else if (drive_stop && state_q != spg_pkg::SPG_IDLE) begin
            state_q <= spg_pkg::SPG_IDLE;
            out_q <= 1'b0;
        end else begin
            unique case (state_q)
                spg_pkg::SPG_IDLE, spg_pkg::SPG_ARMED: begin
                    if (stop_req) begin
                        state_q <= spg_pkg::SPG_IDLE;
                    end else if (start_req) begin
                        state_q <= spg_pkg::SPG_ARMED;
                        slot_q <= start_slot;
                        act_len_q <= len_q[start_slot];
                        act_wid_q <= wid_q[start_slot];
                        act_cnt_q <= cnt_q[start_slot];
                        phase_q <= '0;
                        emit_q <= '0;
                    end else if (state_q == spg_pkg::SPG_ARMED && drive_pulse) begin
                        state_q <= spg_pkg::SPG_RUN;
                        out_q <= 1'b1;
                        emit_q <= CW'(16'h0001);
                        phase_q <= phase_nx;
                    end
                end
                spg_pkg::SPG_RUN: begin
                    if (stop_req && !out_q) begin
                        state_q <= spg_pkg::SPG_IDLE;
                    end else begin
                        if (stop_req) state_q <= spg_pkg::SPG_STOPPING;
                        if (drive_pulse) begin
                            phase_q <= phase_nx;
                            if (phase_q == '0) begin
                                out_q <= 1'b1;
                                emit_q <= emit_q + 1'b1;
                            end else if (fall_now) begin
                                out_q <= 1'b0;
                                if (stop_req || last_done) state_q <= spg_pkg::SPG_IDLE;
                            end
                        end
                    end
                end
                spg_pkg::SPG_STOPPING: begin
                    if (drive_pulse) begin
                        phase_q <= phase_nx;
                        if (fall_now) begin
                            out_q <= 1'b0;
                            state_q <= spg_pkg::SPG_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign position_sync_out = out_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop_while_on;
        state_q == spg_pkg::SPG_RUN && out_q && stop_req && !drive_stop && !fall_now;
    endsequence

    sequence s_held_to_width;
        out_q && state_q == spg_pkg::SPG_STOPPING;
    endsequence

    sequence s_last_fall;
        state_q == spg_pkg::SPG_RUN && fall_now && last_done && !drive_stop;
    endsequence

    a_idle_output_low: assert property (state_q == spg_pkg::SPG_IDLE |-> !out_q)
        else $error("output high while idle");
    a_drive_stop_kill: assert property (drive_stop && state_q != spg_pkg::SPG_IDLE
        |=> state_q == spg_pkg::SPG_IDLE && !out_q)
        else $error("drive stop did not halt output");
    a_out_pulse_timed: assert property ($changed(out_q) |-> $past(drive_pulse) || $past(drive_stop))
        else $error("output moved without a drive pulse");
    a_start_arms_gen: assert property (start_req && !stop_req && !drive_stop && state_q == spg_pkg::SPG_IDLE
        |=> state_q == spg_pkg::SPG_ARMED && !out_q)
        else $error("start did not arm");
    a_stop_when_low: assert property (stop_req && !drive_stop && state_q == spg_pkg::SPG_RUN && !out_q
        |=> state_q == spg_pkg::SPG_IDLE)
        else $error("stop ignored");
    a_stop_holds_on: assert property (s_stop_while_on |=> s_held_to_width)
        else $error("stop cut the ON width");
    a_count_bounded: assert property (state_q != spg_pkg::SPG_IDLE && act_cnt_q != '0
        |-> emit_q <= act_cnt_q)
        else $error("emitted more than configured");
    a_phase_in_period: assert property (act_len_q >= 16'h0002 && state_q == spg_pkg::SPG_RUN
        |-> phase_q < act_len_q)
        else $error("phase left the period");
    a_width_fall: assert property (state_q == spg_pkg::SPG_RUN && fall_now && !stop_req && !drive_stop
        |=> !out_q)
        else $error("output not dropped at width");
    a_slot_loaded: assert property (start_req && !stop_req && !drive_stop && state_q == spg_pkg::SPG_IDLE
        |=> act_len_q == $past(len_q[start_slot]) && slot_q == $past(start_slot))
        else $error("slot not latched");
    a_apb_one_wait: assert property (psel && penable && !pready_q |=> pready_q)
        else $error("apb answer late");
    a_count_done_idle: assert property (s_last_fall |=> state_q == spg_pkg::SPG_IDLE && !out_q)
        else $error("count reached but generator still running");
    a_armed_first_pulse: assert property (state_q == spg_pkg::SPG_ARMED && drive_pulse && !start_req && !stop_req
        && !drive_stop |=> state_q == spg_pkg::SPG_RUN && out_q)
        else $error("armed generator missed the first drive pulse");
    a_stop_ends_width: assert property (state_q == spg_pkg::SPG_STOPPING && fall_now && !drive_stop
        |=> state_q == spg_pkg::SPG_IDLE && !out_q)
        else $error("stopping generator did not end at width");

endmodule

`default_nettype wire

/* core/spg_defines.svh */
`ifndef SPG_DEFINES_SVH
`define SPG_DEFINES_SVH

// ==========================================
// Register byte offsets
`define SPG_OFS_CTRL 12'h000
`define SPG_OFS_STATUS 12'h004
`define SPG_OFS_EMIT 12'h008
`define SPG_OFS_SLOT_BASE 12'h010
`define SPG_SLOT_STRIDE 12'h010
`define SPG_OFS_LEN 12'h000
`define SPG_OFS_WID 12'h004
`define SPG_OFS_CNT 12'h008

// ==========================================
// Control and status field positions
`define SPG_CTRL_START 0
`define SPG_CTRL_SLOT_LO 1
`define SPG_CTRL_SLOT_HI 2
`define SPG_CTRL_STOP 3
`define SPG_STAT_STATE_LO 0
`define SPG_STAT_STATE_HI 1
`define SPG_STAT_OUT 2
`define SPG_STAT_SLOT_LO 4
`define SPG_STAT_SLOT_HI 5

// ==========================================
// Pattern slot reset values
`define SPG_LEN_RST0 16'h000A
`define SPG_LEN_RST1 16'h0014
`define SPG_LEN_RST2 16'h03E8
`define SPG_LEN_RST3 16'h2710
`define SPG_WID_RST0 16'h0005
`define SPG_WID_RST1 16'h000A
`define SPG_WID_RST2 16'h01F4
`define SPG_WID_RST3 16'h1388
`define SPG_CNT_RST0 16'h0000
`define SPG_CNT_RST1 16'h0000
`define SPG_CNT_RST2 16'h000A
`define SPG_CNT_RST3 16'h000A

`endif

/* core/spg_pkg.sv */
package spg_pkg;

    typedef enum logic [1:0] {
        SPG_IDLE = 2'b00,
        SPG_ARMED = 2'b01,
        SPG_RUN = 2'b10,
        SPG_STOPPING = 2'b11
    } spg_state_t;

    typedef enum logic [1:0] {
        SPG_FLD_LEN = 2'b00,
        SPG_FLD_WID = 2'b01,
        SPG_FLD_CNT = 2'b10
    } spg_field_t;

endpackage

/* sim/spg_drive_model.sv */
`timescale 1ns/1ns
`default_nettype none

module spg_drive_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Motion request
    input wire logic run,
    input wire logic [1:0] gap,
    // Drive stream
    output logic drive_pulse,
    output logic drive_active
);
    logic [1:0] gap_q;

    // ==========================================
    // Pulse every gap+1 cycles, silent when not running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_pulse <= 1'b0;
            drive_active <= 1'b0;
            gap_q <= 2'h0;
        end else begin
            drive_active <= run;
            drive_pulse <= run && gap_q == 2'h0;
            gap_q <= (!run || gap_q == 2'h0) ? gap : gap_q - 2'h1;
        end
    end
endmodule

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    logic pclk, presetn, psel, penable, pwrite, jog_start_cmd, jog_stop_cmd, run, e, om, da_q;
    logic pready, pslverr, drive_pulse, drive_active, position_sync_out;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] jog_slot, gap, sl;
    int err_total, check_count, seed, st, ph, em, ml, mw, mc, ln, wd, i;
    int l[4], w[4], c[4];
    wire logic wr = psel & penable & pready & pwrite;
    wire logic go = (wr && paddr == 12'h000 && pwdata[0]) || jog_start_cmd;
    wire logic stp = (wr && paddr == 12'h000 && pwdata[3]) || jog_stop_cmd;
    wire logic [1:0] gs = jog_start_cmd ? jog_slot : pwdata[2:1];
    wire logic [1:0] ws = paddr[5:4] - 2'h1;

    spg_top spg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .drive_pulse(drive_pulse), .drive_active(drive_active), .jog_start_cmd(jog_start_cmd),
        .jog_slot(jog_slot), .jog_stop_cmd(jog_stop_cmd), .position_sync_out(position_sync_out));
    spg_drive_model spg_drive_model_i (.pclk(pclk), .presetn(presetn), .run(run), .gap(gap),
        .drive_pulse(drive_pulse), .drive_active(drive_active));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // ==========================================
    // Reference model
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l <= '{10, 20, 1000, 10000};
            w <= '{5, 10, 500, 5000};
            c <= '{0, 0, 10, 10};
            st <= 0;
            om <= 1'b0;
            da_q <= 1'b0;
        end else begin
            da_q <= drive_active;
            if (wr && paddr >= 12'h010 && paddr < 12'h050) begin
                case (paddr[3:2])
                    2'h0: l[ws] <= pwdata[15:0];
                    2'h1: w[ws] <= pwdata[15:0];
                    2'h2: c[ws] <= pwdata[15:0];
                    default: ;
                endcase
            end
            if (da_q && !drive_active && st != 0) begin
                st <= 0;
                om <= 1'b0;
            end else if (st < 2 && stp) begin
                st <= 0;
            end else if (st < 2 && go) begin
                st <= 1;
                sl <= gs;
                ml <= l[gs];
                mw <= w[gs];
                mc <= c[gs];
            end else if (drive_pulse && st == 1) begin
                st <= 2;
                om <= 1'b1;
                ph <= 0;
                em <= 0;
            end else if (st == 2 && stp && !om) begin
                st <= 0;
            end else if (st >= 2) begin
                if (st == 2 && stp) st <= 3;
                if (drive_pulse) begin
                    ph <= (ph + 1 == ml) ? 0 : ph + 1;
                    if (ph + 1 == ml && st == 2) om <= 1'b1;
                    if (ph + 1 == mw) begin
                        om <= 1'b0;
                        em <= em + 1;
                        if (st == 3 || stp || (mc != 0 && em + 1 == mc)) st <= 0;
                    end
                end
            end
        end
    end

    // ==========================================
    // Checking and bus tasks
    task give_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask

    task chk_bit(input string n, input logic x, input logic g);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", n, x, g);
        end
    endtask

    task apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task rd_chk(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk_word("prdata", x, rd);
    endtask

    function automatic logic [11:0] sa(input int s, input int f);
        return 12'h010 + 12'(s * 16 + f * 4);
    endfunction

    task wait_idle;
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (st != 0 && k < 3000);
        chk_word("model state", 32'h0, 32'(st));
    endtask

    task wait_pulse;
        do @(posedge pclk); while (!drive_pulse);
    endtask

    task jog(input logic s, input logic [1:0] n);
        jog_start_cmd <= s;
        jog_stop_cmd <= !s;
        jog_slot <= n;
        @(posedge pclk);
        jog_start_cmd <= 1'b0;
        jog_stop_cmd <= 1'b0;
    endtask

    always @(negedge pclk) if (presetn) chk_bit("position_sync_out", om, position_sync_out);

    initial begin
        repeat (40000) @(posedge pclk);
        err_total++;
        give_verdict;
    end

    // ==========================================
    // Scenarios
    initial begin
        seed = 47906;
        {presetn, psel, penable, pwrite, jog_start_cmd, jog_stop_cmd, run} <= 7'h00;
        {paddr, pwdata, jog_slot, gap} <= 48'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 12; i++)
            rd_chk(sa(i / 3, i % 3), i % 3 == 0 ? l[i / 3] : i % 3 == 1 ? w[i / 3] : c[i / 3]);
        apb(1'b0, 12'h00C, 32'h0);
        chk_word("pslverr", 32'h1, {31'h0, e});
        chk_word("unmapped", 32'h0, rd);
        ln = 3 + ($random(seed) & 3);
        wd = 1 + ($random(seed) & 1);
        apb(1'b1, sa(0, 0), 32'(ln));
        apb(1'b1, sa(0, 1), 32'(wd));
        apb(1'b1, sa(0, 2), 32'h3);
        rd_chk(sa(0, 0), 32'(ln));
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk_word("status", {27'h0, sl, 3'h1}, {27'h0, rd[5:4], rd[2:0]});
        gap <= 2'($random(seed));
        run <= 1'b1;
        wait_idle;
        run <= 1'b0;
        rd_chk(12'h008, 32'h3);
        jog(1'b1, 2'h1);
        gap <= 2'h3;
        run <= 1'b1;
        do wait_pulse; while (!om);
        jog(1'b0, 2'h0);
        wait_idle;
        run <= 1'b0;
        apb(1'b1, sa(2, 0), 32'h4);
        apb(1'b1, sa(2, 1), 32'h1);
        apb(1'b1, sa(2, 2), 32'h0);
        apb(1'b1, 12'h000, 32'h5);
        run <= 1'b1;
        do wait_pulse; while (!(st == 2 && ph == 1));
        apb(1'b1, 12'h000, 32'h8);
        repeat (20) @(posedge pclk);
        run <= 1'b0;
        apb(1'b1, sa(3, 0), 32'h6);
        apb(1'b1, sa(3, 1), 32'h3);
        jog(1'b1, 2'h3);
        gap <= 2'($random(seed));
        run <= 1'b1;
        do @(posedge pclk); while (!om);
        run <= 1'b0;
        repeat (10) @(posedge pclk);
        run <= 1'b1;
        repeat (40) @(posedge pclk);
        run <= 1'b0;
        apb(1'b0, 12'h004, 32'h0);
        chk_word("status", 32'h0, {29'h0, rd[2:0]});
        give_verdict;
    end
endmodule

`default_nettype wire
